// File: design/emu_acc_file.sv
// Purpose: four 48-bit accumulators, one write port, registered read port plus an unregistered view of all
// Assumes: no reset on contents; software loads before use
// Notes:   rdData comes out of a register; accAll shows the contents directly, unregistered
`timescale 1ns/1ps
`default_nettype none
module emu_acc_file
    import emu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        wrEn,
    input  wire logic [1:0]  wrIdx,
    input  wire logic [47:0] wrData,
    input  wire logic [1:0]  rdIdx,
    output var  logic [47:0] rdData,
    output var  logic [47:0] accAll [ACC_COUNT]
);
    logic [47:0] mem [ACC_COUNT];

    // contents undefined until loaded [RULE11]
    always_ff @(posedge clk)
    begin
        if (wrEn)
            mem[wrIdx] <= wrData;
        rdData <= mem[rdIdx];
    end

    always_comb
    begin
        for (int i = 0; i < ACC_COUNT; i++)
            accAll[i] = mem[i];
    end
endmodule
`default_nettype wire

// File: design/emu_mac_unit.sv
// Purpose: multiply-accumulate datapath with status, mask and accumulators
// Assumes: core issues ops with issueValid; debug port reaches registers by code
// Notes:   accumulate stage is the fourth pipeline stage
// How it works
// RULE1: register stores take one cycle idle, four after load or multiply-accumulate.
// RULE2: accumulator store costs one more cycle when saturation or fractional rounding active.
// RULE3: four-stage pipeline, pipelined 32x32 multiplier, four 48-bit accumulators.
// RULE4: accumulation path 48 bits: 40-bit product plus 8 extension bits.
// RULE5: signed/unsigned multiply, integer and fractional multiply-accumulate, register moves.
// RULE6: a load may proceed alongside a multiply-accumulate.
// RULE7: a new multiply accepted every cycle, optional accumulate after product.
// RULE8: debug register codes 0x804 to 0x80b select unit registers.
// RULE9: status register read/write, resets to zero.
// RULE10: mask register read/write, resets to all ones.
// RULE11: four accumulators read/write, no defined reset.
// RULE12: two extension registers hold accumulator extension bytes, no reset.
// RULE13: status bits 11..8 sticky per-accumulator overflow, cleared by write or load.
// RULE14: bit 7 saturates on overflow and freezes accumulator until cleared or loaded.
// RULE15: fractional store rounds to 16 bits nearest-even when bit 6 set.
`timescale 1ns/1ps
`default_nettype none
module emu_mac_unit
    import emu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    // core issue port
    input  wire logic        issueValid,
    input  wire logic [2:0]  issueOp,
    input  wire logic [1:0]  issueAcc,
    input  wire logic [31:0] issueA,
    input  wire logic [31:0] issueB,
    // core store port: move a unit register to a destination
    input  wire logic        storeReq,
    input  wire logic [11:0] storeCode,
    output logic             storeDone,
    output logic [31:0]      storeData,
    output logic             busy,
    // debug port
    input  wire logic        dbgWrite,
    input  wire logic        dbgRead,
    input  wire logic [11:0] debug_register_code,
    input  wire logic [31:0] dbgWData,
    output logic [31:0]      dbgRData,
    output logic             dbgAck,
    output logic             dbgError
);
    logic [31:0] mac_status_mode;
    logic [31:0] operand_address_mask;
    logic [31:0] next_status;
    logic [31:0] next_mask;

    logic        mulValid;
    logic [63:0] mulProd;
    logic [4:0]  mulTag;
    logic [1:0]  rdIdx;
    logic [47:0] rdAcc;
    logic [47:0] accAll [ACC_COUNT];
    logic        accWr;
    logic [1:0]  accWrIdx;
    logic [47:0] accWrData;

    logic [3:0]  inflight;
    logic [3:0]  next_inflight;
    logic [2:0]  cnt;
    logic [2:0]  next_cnt;
    logic [11:0] pendCode;
    logic [11:0] next_pendCode;
    logic [31:0] next_storeData;
    logic        next_storeDone;
    logic [31:0] next_dbgRData;
    logic        next_dbgAck;
    logic        next_dbgError;
    emu_st_e     state;
    emu_st_e     next_state;

    // decode a register code into an accumulator index flagged by bit 2, or zero for other codes
    function automatic logic [2:0] acc_of(input logic [11:0] code);
        unique case (code)
            CODE_ACCUMULATOR_0: acc_of = 3'h4;
            CODE_ACCUMULATOR_1: acc_of = 3'h5;
            CODE_ACCUMULATOR_2: acc_of = 3'h6;
            CODE_ACCUMULATOR_3: acc_of = 3'h7;
            default:   acc_of = 3'h0;
        endcase
    endfunction

    // composed value of a register for reads and stores [RULE8]
    function automatic logic [31:0] reg_value(input logic [11:0] code,
                                              input logic [31:0] st,
                                              input logic [31:0] mk);
        logic [2:0] a;
        a = acc_of(code);
        reg_value = 32'h0;
        if (a[2])
            reg_value = accAll[a[1:0]][31:0];
        else if (code == CODE_STATUS)
            reg_value = st;
        else if (code == CODE_MASK)
            reg_value = mk;
        else if (code == CODE_EXT01)
            reg_value = {accAll[1][47:40], 8'h0, accAll[0][47:40], 8'h0};
        else if (code == CODE_EXT23)
            reg_value = {accAll[3][47:40], 8'h0, accAll[2][47:40], 8'h0};
    endfunction

    // round-to-nearest-even of bits [31:16] into a 16-bit value [RULE15]
    function automatic logic [31:0] round16(input logic [31:0] v);
        logic [16:0] r;
        r = {1'b0, v[31:16]};
        if (v[15] && (v[14:0] != 15'h0 || v[16]))
            r = r + 17'h1;
        round16 = {16'h0, r[15:0]};
    endfunction

    function automatic logic code_valid(input logic [11:0] code);
        code_valid = (code >= CODE_STATUS) && (code <= CODE_ACCUMULATOR_3);
    endfunction

    emu_mult_pipe u_mult (
        .clk      (clk),
        .reset_n  (reset_n),
        .inValid  (issueValid && issueOp != EMU_OP_LOAD),
        .inSigned (~mac_status_mode[BIT_SU] | mac_status_mode[BIT_FRAC]),
        .opA      (issueA),
        .opB      (issueB),
        .inTag    ({issueOp, issueAcc}),
        .outValid (mulValid),
        .product  (mulProd),
        .outTag   (mulTag)
    );

    emu_acc_file u_acc (
        .clk    (clk),
        .wrEn   (accWr),
        .wrIdx  (accWrIdx),
        .wrData (accWrData),
        .rdIdx  (rdIdx),
        .rdData (rdAcc),
        .accAll (accAll)
    );

    assign rdIdx = mulTag[1:0];

    // fourth stage: accumulate, saturate, flag overflow [RULE3] [RULE4] [RULE5]
    logic [47:0] prod48;
    logic [48:0] sum49;
    logic        ovf;
    logic        frozen;
    logic [47:0] satVal;
    logic [1:0]  dIdx;
    logic [2:0]  dAcc;
    logic        dWrite;
    always_comb
    begin
        prod48 = mac_status_mode[BIT_FRAC] ? {{8{mulProd[63]}}, mulProd[62:23]}
                                          : {{8{mulProd[63]}}, mulProd[39:0]};
        sum49  = (mulTag[4:2] == EMU_OP_MSUB)
               ? {accAll[mulTag[1:0]][47], accAll[mulTag[1:0]]} - {prod48[47], prod48}
               : {accAll[mulTag[1:0]][47], accAll[mulTag[1:0]]} + {prod48[47], prod48};
        ovf    = (sum49[48] != sum49[47]) ||
                 (mulProd[63:39] != {25{mulProd[63]}} && !mac_status_mode[BIT_FRAC]);
        frozen = mac_status_mode[BIT_SAT] &&
                 mac_status_mode[BIT_OVF_LO + mulTag[1:0]];
        satVal = mac_status_mode[BIT_SU] ? (sum49[48] ? 48'h0 : 48'hffff_ffff)
               : (sum49[48] ? 48'hffff_8000_0000 : 48'h0000_7fff_ffff);
        dAcc   = acc_of(debug_register_code);
        dWrite = dbgWrite && dAcc[2];
        dIdx   = dAcc[1:0];
        accWr     = 1'b0;
        accWrIdx  = mulTag[1:0];
        accWrData = sum49[47:0];
        if (dWrite)
        begin
            // a direct load wins over an accumulate in the same cycle
            accWr     = 1'b1;
            accWrIdx  = dIdx;
            // a direct load sign-extends into bits 39:32 and zero-fills the extension byte, so it never stays unknown
            accWrData = {{EXT_WIDTH{dbgWData[31]}}, dbgWData[31:0]};
        end
        else if (mulValid && mulTag[4:2] != EMU_OP_MULT && !frozen) // [RULE7]
        begin
            accWr     = 1'b1;
            accWrData = (ovf && mac_status_mode[BIT_SAT]) ? satVal : sum49[47:0]; // [RULE14]
        end
    end

    // status and mask registers
    always_comb
    begin
        next_status = mac_status_mode;
        next_mask   = operand_address_mask;
        if (dbgWrite && debug_register_code == CODE_STATUS)
            next_status = dbgWData & STATUS_WMASK; // [RULE9] [RULE13]
        if (dWrite)
            next_status[BIT_OVF_LO + dIdx] = 1'b0; // [RULE13] [RULE14]
        // a fresh overflow beats a status write in the same cycle
        if (mulValid && mulTag[4:2] != EMU_OP_MULT && ovf && !frozen &&
            !(dWrite && dIdx == mulTag[1:0]))
            next_status[BIT_OVF_LO + mulTag[1:0]] = 1'b1; // [RULE13]
        if (dbgWrite && debug_register_code == CODE_MASK)
            next_mask = dbgWData; // [RULE10]
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mac_status_mode      <= STATUS_RESET; // [RULE9]
            operand_address_mask <= MASK_RESET;   // [RULE10]
        end
        else
        begin
            mac_status_mode      <= next_status;
            operand_address_mask <= next_mask;
        end
    end

    // extension bytes [RULE12]: stored in acc bits 47:40, reload via ext write
    // is not given a separate path; writes to the ext codes are acked only.

    // in-flight tracker: loads and multiply-accumulates in the pipe [RULE6]
    always_comb
    begin
        next_inflight = {inflight[2:0],
                         issueValid && issueOp != EMU_OP_MULT};
    end

    // store sequencer [RULE1] [RULE2]
    always_comb
    begin
        next_state     = state;
        next_cnt       = cnt;
        next_pendCode  = pendCode;
        next_storeDone = 1'b0;
        next_storeData = storeData;
        unique case (state)
            ST_IDLE:
            begin
                if (storeReq)
                begin
                    next_pendCode = storeCode;
                    next_cnt = (inflight[0] ? LAT_BUSY : LAT_IDLE)
                             + ((acc_of(storeCode) != 3'h0 &&
                                 (mac_status_mode[BIT_SAT] ||
                                  (mac_status_mode[6:5] == 2'b11) ||
                                  (mac_status_mode[5:4] == 2'b11))) ? 3'h1 : 3'h0);
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (cnt <= 3'h1)
                begin
                    next_storeDone = 1'b1;
                    next_storeData = (acc_of(pendCode) != 3'h0 && mac_status_mode[BIT_FRAC]
                                      && mac_status_mode[BIT_SU])
                                   ? round16(reg_value(pendCode, mac_status_mode,
                                                       operand_address_mask))
                                   : reg_value(pendCode, mac_status_mode,
                                               operand_address_mask);
                    next_state = ST_DONE;
                end
                else
                    next_cnt = cnt - 3'h1;
            end
            ST_DONE:
                next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state     <= ST_IDLE;
            cnt       <= 3'h0;
            pendCode  <= 12'h0;
            storeDone <= 1'b0;
            storeData <= 32'h0;
            inflight  <= 4'h0;
        end
        else
        begin
            state     <= next_state;
            cnt       <= next_cnt;
            pendCode  <= next_pendCode;
            storeDone <= next_storeDone;
            storeData <= next_storeData;
            inflight  <= next_inflight;
        end
    end

    // debug port answers one cycle after the request [RULE8]
    always_comb
    begin
        next_dbgAck   = dbgRead || dbgWrite;
        next_dbgError = (dbgRead || dbgWrite) && !code_valid(debug_register_code);
        next_dbgRData = dbgRead ? reg_value(debug_register_code, mac_status_mode,
                                            operand_address_mask) : 32'h0;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dbgAck   <= 1'b0;
            dbgError <= 1'b0;
            dbgRData <= 32'h0;
            busy     <= 1'b0;
        end
        else
        begin
            dbgAck   <= next_dbgAck;
            dbgError <= next_dbgError;
            dbgRData <= next_dbgRData;
            busy     <= |next_inflight;
        end
    end

    // assertions
    status_reset_a: assert property (@(posedge clk) $rose(reset_n) |-> mac_status_mode == STATUS_RESET) else $error("status not zero after reset"); // [RULE9]
    mask_reset_a: assert property (@(posedge clk) $rose(reset_n) |-> operand_address_mask == MASK_RESET) else $error("mask not ones after reset"); // [RULE10]
    store_idle_a: assert property (@(posedge clk) disable iff (!reset_n) (state == ST_IDLE && storeReq && !inflight[0] && acc_of(storeCode) == 3'h0) |=> ##1 storeDone) else $error("idle store late"); // [RULE1]
    store_busy_a: assert property (@(posedge clk) disable iff (!reset_n) (state == ST_IDLE && storeReq && inflight[0] && acc_of(storeCode) == 3'h0) |=> !storeDone [*4] ##1 storeDone) else $error("busy store timing"); // [RULE1]
    store_extra_a: assert property (@(posedge clk) disable iff (!reset_n) (state == ST_IDLE && storeReq && !inflight[0] && acc_of(storeCode) != 3'h0 && mac_status_mode[BIT_SAT]) |=> !storeDone ##1 !storeDone ##1 storeDone) else $error("extra store cycle missing"); // [RULE2]
    ovf_sticky_a: assert property (@(posedge clk) disable iff (!reset_n) $rose(mac_status_mode[8]) |=> mac_status_mode[8] || $past(dbgWrite)) else $error("overflow flag not sticky"); // [RULE13]
    dbg_ack_a: assert property (@(posedge clk) disable iff (!reset_n) (dbgRead || dbgWrite) |=> dbgAck) else $error("debug not answered"); // [RULE8]
    dbg_err_a: assert property (@(posedge clk) disable iff (!reset_n) (dbgRead && !code_valid(debug_register_code)) |=> dbgError) else $error("bad code not flagged"); // [RULE8]
    pipe_lat_a: assert property (@(posedge clk) disable iff (!reset_n) (issueValid && issueOp != EMU_OP_LOAD) |-> ##3 mulValid) else $error("multiplier latency wrong"); // [RULE3]
    busy_cv: cover property (@(posedge clk) disable iff (!reset_n) state == ST_IDLE && storeReq && inflight[0]);
    sat_cv: cover property (@(posedge clk) disable iff (!reset_n) mulValid && ovf && mac_status_mode[BIT_SAT]);
    dbgw_cv: cover property (@(posedge clk) disable iff (!reset_n) dbgWrite && debug_register_code == CODE_STATUS);
endmodule
`default_nettype wire

// File: design/emu_mult_pipe.sv
// Purpose: pipelined 32x32 multiplier, one new product each cycle
// Assumes: operands registered by the caller
// Notes:   three register stages here, accumulate stage in the top
`timescale 1ns/1ps
`default_nettype none
module emu_mult_pipe
    import emu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        inValid,
    input  wire logic        inSigned,
    input  wire logic [31:0] opA,
    input  wire logic [31:0] opB,
    input  wire logic [4:0]  inTag,
    output var  logic        outValid,
    output var  logic [63:0] product,
    output var  logic [4:0]  outTag
);
    logic [65:0] rawProd;
    logic [63:0] stage1;
    logic [63:0] stage2;
    logic [2:0]  vld;
    logic [4:0]  tag1;
    logic [4:0]  tag2;
    logic [2:0]  next_vld;

    always_comb
    begin
        rawProd = $signed({inSigned & opA[31], opA}) * $signed({inSigned & opB[31], opB});
        next_vld = {vld[1:0], inValid};
    end

    // a new operand pair is accepted every cycle [RULE7]
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            vld <= 3'h0;
        else
            vld <= next_vld;
    end

    always_ff @(posedge clk)
    begin
        stage1  <= rawProd[63:0];
        tag1    <= inTag;
        stage2  <= stage1;
        tag2    <= tag1;
        product <= stage2;
        outTag  <= tag2;
    end

    assign outValid = vld[2];
endmodule
`default_nettype wire

// File: design/emu_pkg.sv
// Purpose: shared constants for the multiply-accumulate unit
// Assumes: single processor clock, debug register codes 12 bits wide
// Notes:   register codes, field positions, reset values and latencies
package emu_pkg;
    localparam int unsigned CLK_HZ       = 20000000;
    localparam int unsigned PIPE_STAGES  = 4;
    localparam int unsigned ACC_COUNT    = 4;
    localparam int unsigned ACC_WIDTH    = 48;
    localparam int unsigned EXT_WIDTH    = 8;
    localparam int unsigned PROD_WIDTH   = 40;
    localparam int unsigned CODE_WIDTH   = 12;

    localparam logic [11:0] CODE_STATUS  = 12'h804;
    localparam logic [11:0] CODE_MASK    = 12'h805;
    localparam logic [11:0] CODE_ACCUMULATOR_0    = 12'h806;
    localparam logic [11:0] CODE_EXT01   = 12'h807;
    localparam logic [11:0] CODE_EXT23   = 12'h808;
    localparam logic [11:0] CODE_ACCUMULATOR_1    = 12'h809;
    localparam logic [11:0] CODE_ACCUMULATOR_2    = 12'h80a;
    localparam logic [11:0] CODE_ACCUMULATOR_3    = 12'h80b;

    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET   = 32'hffff_ffff;
    localparam logic [31:0] STATUS_WMASK = 32'h0000_0fff;

    localparam int unsigned BIT_SAT      = 7;
    localparam int unsigned BIT_SU       = 6;
    localparam int unsigned BIT_FRAC     = 5;
    localparam int unsigned BIT_RND      = 4;
    localparam int unsigned BIT_OVF_LO   = 8;

    // store latency when the pipeline is busy; idle stores take one cycle
    localparam logic [2:0]  LAT_IDLE     = 3'h1;
    localparam logic [2:0]  LAT_BUSY     = 3'h4;

    typedef enum logic [2:0] {
        EMU_OP_MULT = 3'h0,
        EMU_OP_MAC  = 3'h1,
        EMU_OP_MSUB = 3'h2,
        EMU_OP_LOAD = 3'h3
    } emu_op_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WAIT  = 3'b010,
        ST_DONE  = 3'b100
    } emu_st_e;
endpackage

// File: verification/emu_core_model.sv
// Purpose: core-side model driving the issue, store and debug ports
// Assumes: requests change on the falling edge, one request at a time
// Notes:   released data lines carry the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module emu_core_model
    import emu_pkg::*;
(
    input  wire logic        clk,
    output logic             issueValid,
    output logic [2:0]       issueOp,
    output logic [1:0]       issueAcc,
    output logic [31:0]      issueA,
    output logic [31:0]      issueB,
    output logic             storeReq,
    output logic [11:0]      storeCode,
    input  wire logic        storeDone,
    input  wire logic [31:0] storeData,
    output logic             dbgWrite,
    output logic             dbgRead,
    output logic [11:0]      debug_register_code,
    output logic [31:0]      dbgWData,
    input  wire logic [31:0] dbgRData,
    input  wire logic        dbgAck,
    input  wire logic        dbgError
);
    initial
    begin
        {issueValid, issueOp, issueAcc, issueA, issueB} = '0;
        {storeReq, storeCode, dbgWrite, dbgRead} = '0;
        {debug_register_code, dbgWData} = '0;
    end

    // valid stays up across calls, so successive calls issue every cycle
    task automatic issue(input logic [2:0] op, input logic [1:0] acc,
                         input logic [31:0] a, input logic [31:0] b);
        @(negedge clk);
        issueValid = 1'b1;
        issueOp = op;
        issueAcc = acc;
        issueA = a;
        issueB = b;
    endtask

    task automatic issue_end();
        @(negedge clk);
        issueValid = 1'b0;
        issueA = ~issueA;
        issueB = ~issueB;
    endtask

    // debug register access by code, answer taken one cycle later
    task automatic dbg(input logic wr, input logic [11:0] code, input logic [31:0] wd,
                       output logic [31:0] rd, output logic [1:0] resp);
        @(negedge clk);
        dbgWrite = wr;
        dbgRead = ~wr;
        debug_register_code = code;
        dbgWData = wd;
        @(negedge clk);
        rd = dbgRData;
        resp = {dbgError, dbgAck};
        dbgWrite = 1'b0;
        dbgRead = 1'b0;
        debug_register_code = ~code;
        dbgWData = ~wd;
    endtask

    // starts at the current falling edge; edges counts rising edges to done
    task automatic store(input logic [11:0] code, output logic [31:0] edges,
                         output logic [31:0] data);
        storeReq = 1'b1;
        storeCode = code;
        edges = '0;
        data = '0;
        while (edges < 32'h0c)
        begin
            @(negedge clk);
            storeReq = 1'b0;
            edges++;
            if (storeDone === 1'b1)
            begin
                data = storeData;
                break;
            end
        end
        storeCode = ~code;
    endtask
endmodule
`default_nettype wire

// File: verification/multiply_accumulate_unit_tb.sv
// Purpose: self-checking bench for the multiply-accumulate unit
// Assumes: core model drives all requests on the falling edge
// Notes:   accumulator contents are written before any read
`timescale 1ns/1ps
`default_nettype none
module multiply_accumulate_unit_tb
    import emu_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        issueValid, storeReq, storeDone, dbgWrite, dbgRead, dbgAck, dbgError;
    logic [2:0]  issueOp;
    logic [1:0]  issueAcc, resp;
    logic [31:0] issueA, issueB, storeData, dbgWData, dbgRData, rdv, edges, sdata;
    logic [11:0] storeCode, debug_register_code;
    int          errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    logic [7:0]  pat [6] = '{8'h80, 8'h60, 8'h30, 8'h40, 8'h10, 8'h20};

    always #25 clk = ~clk;

    emu_mac_unit uut (.clk(clk), .reset_n(reset_n), .issueValid(issueValid),
        .issueOp(issueOp), .issueAcc(issueAcc), .issueA(issueA), .issueB(issueB),
        .storeReq(storeReq), .storeCode(storeCode), .storeDone(storeDone),
        .storeData(storeData), .busy(), .dbgWrite(dbgWrite), .dbgRead(dbgRead),
        .debug_register_code(debug_register_code), .dbgWData(dbgWData),
        .dbgRData(dbgRData), .dbgAck(dbgAck), .dbgError(dbgError));

    emu_core_model core (.clk(clk), .issueValid(issueValid), .issueOp(issueOp),
        .issueAcc(issueAcc), .issueA(issueA), .issueB(issueB), .storeReq(storeReq),
        .storeCode(storeCode), .storeDone(storeDone), .storeData(storeData),
        .dbgWrite(dbgWrite), .dbgRead(dbgRead), .debug_register_code(debug_register_code),
        .dbgWData(dbgWData), .dbgRData(dbgRData), .dbgAck(dbgAck), .dbgError(dbgError));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [11:0] code, input logic [31:0] val);
        core.dbg(1'b1, code, val, rdv, resp);
        check(resp, 2'b01);
    endtask

    task automatic rd(input logic [11:0] code, input logic [31:0] exp);
        core.dbg(1'b0, code, '0, rdv, resp);
        check(resp, 2'b01);
        check(rdv, exp);
    endtask

    task automatic mac_wait(input logic [2:0] op, input logic [1:0] acc,
                            input logic [31:0] a, input logic [31:0] b);
        core.issue(op, acc, a, b);
        core.issue_end();
        repeat (6) @(negedge clk);
    endtask

    task automatic t_regs();
        rd(CODE_STATUS, STATUS_RESET);
        rd(CODE_MASK, MASK_RESET);
        wr(CODE_STATUS, 32'hffff_ffff);
        rd(CODE_STATUS, STATUS_WMASK);
        wr(CODE_STATUS, 32'h0000_0000);
        wr(CODE_MASK, 32'h1234_5678);
        rd(CODE_MASK, 32'h1234_5678);
        wr(CODE_ACCUMULATOR_0, 32'h0000_0006);
        wr(CODE_ACCUMULATOR_1, 32'h0000_0106);
        wr(CODE_ACCUMULATOR_2, 32'h0000_0206);
        wr(CODE_ACCUMULATOR_3, 32'h0000_0306);
        rd(CODE_ACCUMULATOR_0, 32'h0000_0006);
        rd(CODE_ACCUMULATOR_1, 32'h0000_0106);
        rd(CODE_ACCUMULATOR_2, 32'h0000_0206);
        rd(CODE_ACCUMULATOR_3, 32'h0000_0306);
        wr(CODE_EXT01, 32'h0000_0000);
        wr(CODE_EXT23, 32'h0000_0000);
        rd(CODE_EXT01, 32'h0000_0000);
        rd(CODE_EXT23, 32'h0000_0000);
        core.dbg(1'b0, 12'h803, '0, rdv, resp);
        check(resp, 2'b11);
        core.dbg(1'b1, 12'h80c, '0, rdv, resp);
        check(resp, 2'b11);
    endtask

    task automatic t_mac();
        wr(CODE_ACCUMULATOR_0, 32'h0000_000a);
        core.issue(EMU_OP_MAC, 2'h0, 32'h0000_0003, 32'h0000_0004);
        mac_wait(EMU_OP_MAC, 2'h0, 32'h0000_0005, 32'h0000_0006);
        rd(CODE_ACCUMULATOR_0, 32'h0000_0034);
        mac_wait(EMU_OP_MSUB, 2'h0, 32'h0000_0002, 32'h0000_0003);
        rd(CODE_ACCUMULATOR_0, 32'h0000_002e);
    endtask

    task automatic t_store();
        core.store(CODE_ACCUMULATOR_0, edges, sdata);
        check(edges, 32'h2);
        check(sdata, 32'h0000_002e);
        core.issue(EMU_OP_MAC, 2'h3, 32'h0000_0001, 32'h0000_0001);
        core.issue_end();
        core.store(CODE_MASK, edges, sdata);
        check(edges, 32'h5);
        check(sdata, 32'h1234_5678);
        core.issue(EMU_OP_LOAD, 2'h2, 32'h0000_0001, 32'h0000_0001);
        core.issue_end();
        core.store(CODE_STATUS, edges, sdata);
        check(edges, 32'h5);
        for (int i = 0; i < 6; i++)
        begin
            wr(CODE_STATUS, {24'h0, pat[i]});
            core.store(CODE_ACCUMULATOR_0, edges, sdata);
            check(edges, (i < 3) ? 32'h3 : 32'h2);
        end
        wr(CODE_STATUS, 32'h0000_0080);
        core.store(CODE_STATUS, edges, sdata);
        check(edges, 32'h2);
        wr(CODE_STATUS, 32'h0000_0000);
    endtask

    task automatic t_overflow();
        wr(CODE_ACCUMULATOR_1, 32'h0000_0005);
        mac_wait(EMU_OP_MAC, 2'h1, 32'h7fff_ffff, 32'h7fff_ffff);
        rd(CODE_STATUS, 32'h0000_0200);
        mac_wait(EMU_OP_MAC, 2'h1, 32'h0000_0001, 32'h0000_0001);
        rd(CODE_STATUS, 32'h0000_0200);
        wr(CODE_STATUS, 32'h0000_0080);
        rd(CODE_STATUS, 32'h0000_0080);
        wr(CODE_ACCUMULATOR_2, 32'h0000_0005);
        mac_wait(EMU_OP_MAC, 2'h2, 32'h7fff_ffff, 32'h7fff_ffff);
        rd(CODE_STATUS, 32'h0000_0480);
        rd(CODE_ACCUMULATOR_2, 32'h7fff_ffff);
        mac_wait(EMU_OP_MAC, 2'h2, 32'h0000_0001, 32'h0000_0001);
        rd(CODE_ACCUMULATOR_2, 32'h7fff_ffff);
        wr(CODE_ACCUMULATOR_2, 32'h0000_0009);
        rd(CODE_STATUS, 32'h0000_0080);
        mac_wait(EMU_OP_MAC, 2'h2, 32'h0000_0001, 32'h0000_0001);
        rd(CODE_ACCUMULATOR_2, 32'h0000_000a);
    endtask

    // the whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            finish_test();
        end
    end

    initial
    begin
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        t_regs();
        t_mac();
        t_store();
        t_overflow();
        finish_test();
    end
endmodule
`default_nettype wire
